// ==== rtl/rcs_radio_regs.sv ====
// Summary of operation
// - Retransmit limit zero disables retries; N allows up to N retries on failed acknowledgment.
// - Seven-bit channel field selects frequency, resets to 2; top bit stays zero.
// - Setup bit 7 turns on continuous carrier transmit; resets to zero.
// - Rate pair decodes 1M, 2M, 250k; high bit ignored while low bit set.
// - Setup bit 4 forces the PLL lock indication, test use, resets zero.
// - Output power field at bits 2:1 selects -18 to 0 dBm, resets 11.
// - Status byte shifts out on MISO while the command byte shifts in.
// - Receive data ready flag sets on new data; host writes one to clear.
// - Data sent flag sets on transmit; with auto acknowledge, only on acknowledgment.
// - Retransmit limit flag sets and blocks traffic until the host clears it.
// - Status bits 3:1 give pending pipe number, 111 when empty; read-only.
// - Status bit 0 reads one while the transmit FIFO is full.
// - Lost packet count at bits 7:4 saturates at 15.
// - Any write to the channel register clears the lost packet count.
// - Retransmit tally at bits 3:0 clears when a new packet starts, unless the retransmit limit flag is set.
// - Power detector at bit 0; bits 7:1 read zero.
// - Pipe 0 address holds 40 bits, resets to E7E7E7E7E7.
// - Address width 01, 10, 11 mean 3, 4, 5 bytes; 00 illegal.
// - Each status flag pulls the interrupt pin low unless its mask bit is set.
`timescale 1ns/1ps
module rcs_radio_regs (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        sck,
	input  wire logic        csn_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	output logic             irq_n,
	input  wire logic        rx_data_arrived,
	input  wire logic        tx_packet_sent,
	input  wire logic        ack_received,
	input  wire logic        ack_missed,
	input  wire logic        new_packet_start,
	input  wire logic        auto_acknowledge,
	input  wire logic [2:0]  rx_pipe_number,
	input  wire logic        tx_fifo_full,
	input  wire logic        power_detect_in,
	output logic [6:0]       radio_channel,
	output logic             continuous_carrier,
	output rcs_pkg::rcs_rate_t data_rate,
	output logic             pll_lock_force,
	output logic [1:0]       output_power_level,
	output logic [39:0]      pipe0_receive_address,
	output logic [1:0]       address_width,
	output logic             retransmit_request,
	output logic             comm_blocked
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]          config_reg;
		logic [1:0]          address_width;
		logic [7:0]          retransmit_setup;
		logic [6:0]          radio_channel;
		logic [7:0]          radio_setup;
		logic                receive_data_ready;
		logic                transmit_data_sent;
		logic                retransmit_limit_hit;
		logic [2:0]          pipe_number;
		logic                tx_full;
		logic [3:0]          lost_packet_count;
		logic [3:0]          retransmit_tally;
		logic                power_detect;
		logic [39:0]         pipe0_receive_address;
		rcs_pkg::rcs_phase_t phase;
		logic [4:0]          cmd_addr;
		logic [2:0]          byte_idx;
		logic [7:0]          tx_byte;
		rcs_pkg::rcs_rate_t  data_rate;
		logic                irq_n;
		logic                retransmit_request;
	} rcs_state_t;

	localparam rcs_state_t STATE_RESET = '{
		config_reg:            rcs_pkg::CONFIG_RESET,
		address_width:         rcs_pkg::AW_RESET,
		retransmit_setup:      rcs_pkg::RETR_RESET,
		radio_channel:         rcs_pkg::CHANNEL_RESET,
		radio_setup:           rcs_pkg::SETUP_RESET,
		receive_data_ready:    1'b0,
		transmit_data_sent:    1'b0,
		retransmit_limit_hit:  1'b0,
		pipe_number:           rcs_pkg::PIPE_EMPTY,
		tx_full:               1'b0,
		lost_packet_count:     4'h0,
		retransmit_tally:      4'h0,
		power_detect:          1'b0,
		pipe0_receive_address: rcs_pkg::PIPE0_RESET,
		phase:                 rcs_pkg::PH_CMD,
		cmd_addr:              5'h00,
		byte_idx:              3'h0,
		tx_byte:               8'h00,
		data_rate:             rcs_pkg::RATE_2M,
		irq_n:                 1'b1,
		retransmit_request:    1'b0
	};

	rcs_state_t s;
	rcs_state_t next_s;
	logic [1:0] rst_sync;
	logic       rst_n;

	rcs_spi_link_if link ();

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [2:0] width_bytes(input logic [1:0] aw);
		unique case (aw)
			2'h1:    width_bytes = 3'h3;
			2'h2:    width_bytes = 3'h4;
			default: width_bytes = 3'h5;
		endcase
	endfunction

	function automatic rcs_pkg::rcs_rate_t rate_decode(input logic [7:0] setup);
		if (setup[rcs_pkg::SETUP_RATE_LOW_BIT]) begin
			rate_decode = rcs_pkg::RATE_250K;
		end else if (setup[rcs_pkg::SETUP_RATE_HIGH_BIT]) begin
			rate_decode = rcs_pkg::RATE_2M;
		end else begin
			rate_decode = rcs_pkg::RATE_1M;
		end
	endfunction

	function automatic logic [7:0] status_byte(input rcs_state_t st);
		status_byte = {1'b0, st.receive_data_ready, st.transmit_data_sent,
			st.retransmit_limit_hit, st.pipe_number, st.tx_full};
	endfunction

	function automatic logic [7:0] read_byte(
		input rcs_state_t st,
		input logic [4:0] addr,
		input logic [2:0] idx
	);
		read_byte = 8'h00;
		if (addr == rcs_pkg::ADDR_PIPE0) begin
			if (idx < width_bytes(st.address_width)) begin
				read_byte = st.pipe0_receive_address[{idx, 3'h0} +: 8];
			end
		end else if (idx == 3'h0) begin
			unique case (addr)
				rcs_pkg::ADDR_CONFIG:     read_byte = st.config_reg;
				rcs_pkg::ADDR_AW_SETUP:   read_byte = {6'h00, st.address_width};
				rcs_pkg::ADDR_RETR_SETUP: read_byte = st.retransmit_setup;
				rcs_pkg::ADDR_CHANNEL:    read_byte = {1'b0, st.radio_channel};
				rcs_pkg::ADDR_SETUP:      read_byte = st.radio_setup;
				rcs_pkg::ADDR_STATUS:     read_byte = status_byte(st);
				rcs_pkg::ADDR_OBSERVE:    read_byte = {st.lost_packet_count, st.retransmit_tally};
				rcs_pkg::ADDR_POWER:      read_byte = {7'h00, st.power_detect};
				default:                  read_byte = 8'h00;
			endcase
		end
	endfunction

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	rcs_spi_shifter u_shifter (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.sck   (sck),
		.csn_n (csn_n),
		.mosi  (mosi),
		.link  (link.shifter)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.retransmit_request = 1'b0;
		// Read-only fields track the datapath only, never the host
		next_s.pipe_number = rx_pipe_number;
		next_s.tx_full = tx_fifo_full;
		next_s.power_detect = power_detect_in;

		// Host side: command byte then data bytes
		if (!link.frame_active) begin
			next_s.phase = rcs_pkg::PH_CMD;
			next_s.byte_idx = 3'h0;
			next_s.tx_byte = status_byte(s);
		end else if (link.byte_done) begin
			unique case (s.phase)
				rcs_pkg::PH_CMD: begin
					next_s.cmd_addr = link.rx_byte[4:0];
					next_s.byte_idx = 3'h0;
					if (link.rx_byte[7:5] == rcs_pkg::CMD_READ) begin
						next_s.phase = rcs_pkg::PH_READ;
						next_s.tx_byte = read_byte(s, link.rx_byte[4:0], 3'h0);
					end else if (link.rx_byte[7:5] == rcs_pkg::CMD_WRITE) begin
						next_s.phase = rcs_pkg::PH_WRITE;
						next_s.tx_byte = 8'h00;
					end else begin
						next_s.phase = rcs_pkg::PH_IGNORE;
						next_s.tx_byte = 8'h00;
					end
				end
				rcs_pkg::PH_READ: begin
					if (s.byte_idx != 3'h7) begin
						next_s.byte_idx = s.byte_idx + 3'h1;
					end
					next_s.tx_byte = read_byte(s, s.cmd_addr, next_s.byte_idx);
				end
				rcs_pkg::PH_WRITE: begin
					if (s.byte_idx != 3'h7) begin
						next_s.byte_idx = s.byte_idx + 3'h1;
					end
					next_s.tx_byte = 8'h00;
					unique case (s.cmd_addr)
						rcs_pkg::ADDR_CONFIG: begin
							if (s.byte_idx == 3'h0) begin
								next_s.config_reg = link.rx_byte;
							end
						end
						rcs_pkg::ADDR_AW_SETUP: begin
							// The illegal code is refused so the width stays defined
							if (s.byte_idx == 3'h0 && link.rx_byte[1:0] != 2'h0) begin
								next_s.address_width = link.rx_byte[1:0];
							end
						end
						rcs_pkg::ADDR_RETR_SETUP: begin
							if (s.byte_idx == 3'h0) begin
								next_s.retransmit_setup = link.rx_byte;
							end
						end
						rcs_pkg::ADDR_CHANNEL: begin
							if (s.byte_idx == 3'h0) begin
								next_s.radio_channel = link.rx_byte[6:0];
								next_s.lost_packet_count = 4'h0;
							end
						end
						rcs_pkg::ADDR_SETUP: begin
							if (s.byte_idx == 3'h0) begin
								next_s.radio_setup = link.rx_byte & rcs_pkg::SETUP_WRITE_MASK;
							end
						end
						rcs_pkg::ADDR_STATUS: begin
							if (s.byte_idx == 3'h0) begin
								next_s.receive_data_ready = s.receive_data_ready
									& ~link.rx_byte[rcs_pkg::STATUS_RX_BIT];
								next_s.transmit_data_sent = s.transmit_data_sent
									& ~link.rx_byte[rcs_pkg::STATUS_TX_BIT];
								next_s.retransmit_limit_hit = s.retransmit_limit_hit
									& ~link.rx_byte[rcs_pkg::STATUS_RT_BIT];
							end
						end
						rcs_pkg::ADDR_PIPE0: begin
							// Bytes beyond the set width are dropped
							if (s.byte_idx < width_bytes(s.address_width)) begin
								next_s.pipe0_receive_address[{s.byte_idx, 3'h0} +: 8] = link.rx_byte;
							end
						end
						default: begin
							next_s.cmd_addr = s.cmd_addr;
						end
					endcase
				end
				rcs_pkg::PH_IGNORE: begin
					next_s.tx_byte = 8'h00;
				end
				default: begin
					next_s.phase = rcs_pkg::PH_IGNORE;
				end
			endcase
		end

		// Radio events come after host writes so a set beats a clear
		if (rx_data_arrived) begin
			next_s.receive_data_ready = 1'b1;
		end
		if ((tx_packet_sent && !auto_acknowledge) || (ack_received && auto_acknowledge)) begin
			next_s.transmit_data_sent = 1'b1;
		end
		if (!s.retransmit_limit_hit) begin
			if (new_packet_start) begin
				next_s.retransmit_tally = 4'h0;
			end else if (ack_missed) begin
				if (s.retransmit_tally < s.retransmit_setup[3:0]) begin
					next_s.retransmit_tally = s.retransmit_tally + 4'h1;
					next_s.retransmit_request = 1'b1;
				end else begin
					next_s.retransmit_limit_hit = 1'b1;
					if (next_s.lost_packet_count != rcs_pkg::COUNT_MAX) begin
						next_s.lost_packet_count = next_s.lost_packet_count + 4'h1;
					end
				end
			end
		end

		next_s.data_rate = rate_decode(next_s.radio_setup);
		next_s.irq_n = !((next_s.receive_data_ready && !next_s.config_reg[rcs_pkg::CONFIG_MASK_RX])
			|| (next_s.transmit_data_sent && !next_s.config_reg[rcs_pkg::CONFIG_MASK_TX])
			|| (next_s.retransmit_limit_hit && !next_s.config_reg[rcs_pkg::CONFIG_MASK_RT]));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= STATE_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.tx_byte = s.tx_byte;
	assign miso = link.miso;
	assign miso_oe = link.miso_oe;
	assign irq_n = s.irq_n;
	assign radio_channel = s.radio_channel;
	assign continuous_carrier = s.radio_setup[rcs_pkg::SETUP_CARRIER_BIT];
	assign data_rate = s.data_rate;
	assign pll_lock_force = s.radio_setup[rcs_pkg::SETUP_PLL_BIT];
	assign output_power_level = s.radio_setup[rcs_pkg::SETUP_POWER_LSB +: 2];
	assign pipe0_receive_address = s.pipe0_receive_address;
	assign address_width = s.address_width;
	assign retransmit_request = s.retransmit_request;
	assign comm_blocked = s.retransmit_limit_hit;

endmodule

// ==== shared/rcs_pkg.sv ====
package rcs_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [4:0] ADDR_CONFIG     = 5'h00;
	localparam logic [4:0] ADDR_AW_SETUP   = 5'h03;
	localparam logic [4:0] ADDR_RETR_SETUP = 5'h04;
	localparam logic [4:0] ADDR_CHANNEL    = 5'h05;
	localparam logic [4:0] ADDR_SETUP      = 5'h06;
	localparam logic [4:0] ADDR_STATUS     = 5'h07;
	localparam logic [4:0] ADDR_OBSERVE    = 5'h08;
	localparam logic [4:0] ADDR_POWER      = 5'h09;
	localparam logic [4:0] ADDR_PIPE0      = 5'h0a;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0]  CONFIG_RESET  = 8'h08;
	localparam logic [1:0]  AW_RESET      = 2'h3;
	localparam logic [7:0]  RETR_RESET    = 8'h03;
	localparam logic [6:0]  CHANNEL_RESET = 7'h02;
	localparam logic [7:0]  SETUP_RESET   = 8'h0e;
	localparam logic [2:0]  PIPE_EMPTY    = 3'h7;
	localparam logic [39:0] PIPE0_RESET   = 40'he7_e7e7_e7e7;

	// ****************************************
	// Field positions and masks
	// ****************************************
	localparam int SETUP_CARRIER_BIT   = 7;
	localparam int SETUP_RATE_LOW_BIT  = 5;
	localparam int SETUP_PLL_BIT       = 4;
	localparam int SETUP_RATE_HIGH_BIT = 3;
	localparam int SETUP_POWER_LSB     = 1;
	localparam logic [7:0] SETUP_WRITE_MASK = 8'hbe;
	localparam int STATUS_RX_BIT   = 6;
	localparam int STATUS_TX_BIT   = 5;
	localparam int STATUS_RT_BIT   = 4;
	localparam int CONFIG_MASK_RX  = 6;
	localparam int CONFIG_MASK_TX  = 5;
	localparam int CONFIG_MASK_RT  = 4;
	localparam logic [3:0] COUNT_MAX = 4'hf;

	// ****************************************
	// Command prefixes, upper three bits
	// ****************************************
	localparam logic [2:0] CMD_READ  = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;

	typedef enum logic [1:0] {
		RATE_1M   = 2'h0,
		RATE_2M   = 2'h1,
		RATE_250K = 2'h2
	} rcs_rate_t;

	typedef enum logic [3:0] {
		PH_CMD    = 4'h1,
		PH_READ   = 4'h2,
		PH_WRITE  = 4'h4,
		PH_IGNORE = 4'h8
	} rcs_phase_t;

endpackage

// ==== shared/rcs_spi_link_if.sv ====
`timescale 1ns/1ps
interface rcs_spi_link_if;
	logic       frame_active;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic       miso;
	logic       miso_oe;

	modport shifter (
		output frame_active,
		output byte_done,
		output rx_byte,
		output miso,
		output miso_oe,
		input  tx_byte
	);

	modport ctrl (
		input  frame_active,
		input  byte_done,
		input  rx_byte,
		input  miso,
		input  miso_oe,
		output tx_byte
	);
endinterface

// ==== rtl/rcs_spi_shifter.sv ====
`timescale 1ns/1ps
module rcs_spi_shifter (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         sck,
	input  wire logic         csn_n,
	input  wire logic         mosi,
	rcs_spi_link_if.shifter   link
);

	typedef struct packed {
		logic       sck_prev;
		logic       frame_active;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic       byte_done;
		logic       miso;
		logic       miso_oe;
	} rcs_shift_state_t;

	localparam rcs_shift_state_t SHIFT_RESET = '0;

	rcs_shift_state_t s;
	rcs_shift_state_t next_s;

	// ****************************************
	// Serial shifting, mode 0, MSB first
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.byte_done = 1'b0;
		next_s.sck_prev = sck;
		next_s.frame_active = !csn_n;
		if (csn_n) begin
			next_s.bit_cnt = 3'h0;
			next_s.miso_oe = 1'b0;
		end else if (!s.frame_active) begin
			// First bit goes out as soon as the frame opens
			next_s.shift_out = {link.tx_byte[6:0], 1'b0};
			next_s.miso = link.tx_byte[7];
			next_s.miso_oe = 1'b1;
			next_s.bit_cnt = 3'h0;
		end else if (sck && !s.sck_prev) begin
			next_s.shift_in = {s.shift_in[6:0], mosi};
			next_s.bit_cnt = s.bit_cnt + 3'h1;
			next_s.byte_done = (s.bit_cnt == 3'h7);
		end else if (!sck && s.sck_prev) begin
			if (s.bit_cnt == 3'h0) begin
				next_s.shift_out = {link.tx_byte[6:0], 1'b0};
				next_s.miso = link.tx_byte[7];
			end else begin
				next_s.shift_out = {s.shift_out[6:0], 1'b0};
				next_s.miso = s.shift_out[7];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= SHIFT_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign link.frame_active = s.frame_active;
	assign link.byte_done = s.byte_done;
	assign link.rx_byte = s.shift_in;
	assign link.miso = s.miso;
	assign link.miso_oe = s.miso_oe;

endmodule

// ==== sim/rcs_radio_regs_monitor.sv ====
`timescale 1ns/1ps
module rcs_radio_regs_monitor (
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              csn_n,
	input wire logic              ack_missed,
	input wire logic              new_packet_start,
	input wire logic              miso_oe,
	input wire logic              retransmit_request,
	input wire logic              comm_blocked,
	input wire logic [6:0]        radio_channel,
	input wire logic [39:0]       pipe0_receive_address,
	input wire logic [1:0]        address_width,
	input wire rcs_pkg::rcs_rate_t data_rate
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// ****************************************
	// Checks
	// ****************************************
	a_oe_rise: assert property ($fell(csn_n) |-> ##[1:3] miso_oe)
		else $error("miso enable did not follow chip select");
	a_oe_release: assert property (csn_n [*4] |-> !miso_oe)
		else $error("miso enable held outside frame");
	// Settings only move through a write frame
	a_cfg_idle: assert property (csn_n [*4] |-> $stable(radio_channel) && $stable(pipe0_receive_address)
		&& $stable(address_width)) else $error("setting changed while bus idle");
	a_retry_cause: assert property (retransmit_request |-> $past(ack_missed) && !$past(comm_blocked))
		else $error("retry without a missed acknowledgment");
	a_miss_answered: assert property (ack_missed && !comm_blocked && !new_packet_start
		|=> retransmit_request || comm_blocked) else $error("missed acknowledgment gave neither retry nor block");
	a_block_cause: assert property ($rose(comm_blocked) |-> $past(ack_missed))
		else $error("block without a missed acknowledgment");
	a_block_hold: assert property (comm_blocked && csn_n && $past(csn_n) |=> comm_blocked)
		else $error("block released without host clear");
	a_rate_legal: assert property (data_rate inside {rcs_pkg::RATE_1M, rcs_pkg::RATE_2M, rcs_pkg::RATE_250K})
		else $error("reserved rate decoded");
	a_width_legal: assert property (address_width != 2'h0)
		else $error("illegal address width accepted");

	c_retry: cover property (retransmit_request);
	c_block: cover property ($rose(comm_blocked));
	c_frame: cover property ($fell(csn_n));
endmodule

// ==== sim/rcs_spi_host.sv ====
`timescale 1ns/1ps
module rcs_spi_host (
	input  wire logic clk,
	input  wire logic miso,
	output logic      sck,
	output logic      csn_n,
	output logic      mosi
);
	initial begin
		sck = 1'b0;
		csn_n = 1'b1;
		mosi = 1'b0;
	end

	// ****************************************
	// One frame: command, then nb data bytes
	// ****************************************
	// Half period of four clocks leaves the device time to load each byte
	task automatic frame(input logic [7:0] cmd, input int nb, input logic [39:0] wd,
		output logic [7:0] st, output logic [39:0] rd);
		logic [7:0] tx;
		logic [7:0] rx;
		rd = '0;
		st = '0;
		@(posedge clk) csn_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int b = 0; b <= nb; b++) begin
			if (b == 0) begin
				tx = cmd;
			end else begin
				tx = wd[8*(b-1) +: 8];
			end
			for (int i = 7; i >= 0; i--) begin
				mosi <= tx[i];
				repeat (4) @(posedge clk);
				sck <= 1'b1;
				rx[i] = miso;
				repeat (4) @(posedge clk);
				sck <= 1'b0;
			end
			if (b == 0) begin
				st = rx;
			end else begin
				rd[8*(b-1) +: 8] = rx;
			end
		end
		repeat (4) @(posedge clk);
		csn_n <= 1'b1;
		// Released line does not keep its last bit
		mosi <= ~mosi;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic              clk;
	logic              arst_n;
	logic              sck;
	logic              csn_n;
	logic              mosi;
	logic              miso;
	logic              miso_oe;
	logic              irq_n;
	logic [4:0]        ev;
	logic              auto_ack;
	logic [2:0]        pipe_no;
	logic              tx_full;
	logic              pwr_in;
	logic [6:0]        radio_channel;
	logic              continuous_carrier;
	rcs_pkg::rcs_rate_t data_rate;
	logic              pll_lock_force;
	logic [1:0]        output_power_level;
	logic [39:0]       pipe0_receive_address;
	logic [1:0]        address_width;
	logic              retransmit_request;
	logic              comm_blocked;
	int                error_cnt = 0;
	int                tests_run = 0;
	int                retry_cnt = 0;
	int                cyc = 0;
	logic [7:0]        v;

	rcs_radio_regs i_rcs_radio_regs (.clk(clk), .arst_n(arst_n), .ce(1'b1), .sck(sck), .csn_n(csn_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .irq_n(irq_n), .rx_data_arrived(ev[0]), .tx_packet_sent(ev[1]),
		.ack_received(ev[2]), .ack_missed(ev[3]), .new_packet_start(ev[4]), .auto_acknowledge(auto_ack),
		.rx_pipe_number(pipe_no), .tx_fifo_full(tx_full), .power_detect_in(pwr_in), .radio_channel(radio_channel),
		.continuous_carrier(continuous_carrier), .data_rate(data_rate), .pll_lock_force(pll_lock_force),
		.output_power_level(output_power_level), .pipe0_receive_address(pipe0_receive_address),
		.address_width(address_width), .retransmit_request(retransmit_request), .comm_blocked(comm_blocked));
	// Undriven line shows the inverse of its last bit, so a late enable is caught
	rcs_spi_host i_rcs_spi_host (.clk(clk), .miso(miso_oe ? miso : ~miso), .sck(sck), .csn_n(csn_n), .mosi(mosi));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (retransmit_request === 1'b1) retry_cnt++;
		cyc++;
		if (cyc == 50000) begin
			error_cnt++;
			results();
		end
	end

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input int nb, input logic [39:0] d);
		logic [7:0] s;
		logic [39:0] r;
		i_rcs_spi_host.frame({rcs_pkg::CMD_WRITE, a}, nb, d, s, r);
	endtask
	task automatic rd(input string nm, input logic [4:0] a, input int nb, input logic [39:0] exp);
		logic [7:0] s;
		logic [39:0] r;
		i_rcs_spi_host.frame({rcs_pkg::CMD_READ, a}, nb, 40'h0, s, r);
		chk(nm, exp, r);
	endtask
	task automatic st_chk(input logic [7:0] exp);
		logic [7:0] s;
		logic [39:0] r;
		i_rcs_spi_host.frame({rcs_pkg::CMD_READ, rcs_pkg::ADDR_STATUS}, 0, 40'h0, s, r);
		chk("status", exp, s);
	endtask
	task automatic ign(input logic [7:0] c, input logic [7:0] exp);
		logic [7:0] s;
		logic [39:0] r;
		i_rcs_spi_host.frame(c, 1, 40'h7f, s, r);
		chk("ignored data", 40'h0, r);
		chk("ignored status", exp, s);
	endtask
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk) ev <= 5'h01 << k;
			@(posedge clk) ev <= 5'h00;
		end
		// Second edge lets the retry counter settle before any compare
		repeat (2) @(posedge clk);
	endtask
	task automatic results();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		arst_n = 1'b0;
		ev = 5'h00;
		auto_ack = 1'b0;
		pipe_no = 3'h7;
		tx_full = 1'b0;
		pwr_in = 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd("channel", rcs_pkg::ADDR_CHANNEL, 1, 40'h02);
		rd("setup", rcs_pkg::ADDR_SETUP, 1, 40'h0e);
		rd("pipe0", rcs_pkg::ADDR_PIPE0, 5, 40'he7_e7e7_e7e7);
		st_chk(8'h0e);
		for (int i = 0; i < 4; i++) begin
			v = {i == 3, 1'b0, i[1], i == 3, i[0], i[1:0], 1'b0};
			wr(rcs_pkg::ADDR_SETUP, 1, {32'h0, v});
			rd("setup", rcs_pkg::ADDR_SETUP, 1, {32'h0, v});
			chk("rate", i[1] ? rcs_pkg::RATE_250K : (i[0] ? rcs_pkg::RATE_2M : rcs_pkg::RATE_1M), data_rate);
			chk("power", i[1:0], output_power_level);
			chk("carrier", i == 3, continuous_carrier);
			chk("pll", i == 3, pll_lock_force);
		end
		pulse(3, 3);
		chk("retries", 3, retry_cnt);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'h03);
		pulse(3, 1);
		chk("blocked", 1'b1, comm_blocked);
		chk("irq", 1'b0, irq_n);
		pulse(3, 1);
		pulse(4, 1);
		chk("retries", 3, retry_cnt);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'h13);
		st_chk(8'h1e);
		wr(rcs_pkg::ADDR_STATUS, 1, 40'h10);
		chk("blocked", 1'b0, comm_blocked);
		pulse(4, 1);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'h10);
		wr(rcs_pkg::ADDR_RETR_SETUP, 1, 40'h00);
		for (int i = 0; i < 15; i++) begin
			pulse(3, 1);
			wr(rcs_pkg::ADDR_STATUS, 1, 40'h10);
		end
		chk("retries", 3, retry_cnt);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'hf0);
		wr(rcs_pkg::ADDR_CHANNEL, 1, 40'h10);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'h00);
		chk("channel", 7'h10, radio_channel);
		pulse(0, 1);
		st_chk(8'h4e);
		chk("irq", 1'b0, irq_n);
		wr(rcs_pkg::ADDR_CONFIG, 1, 40'h48);
		chk("irq", 1'b1, irq_n);
		wr(rcs_pkg::ADDR_STATUS, 1, 40'h40);
		st_chk(8'h0e);
		pulse(1, 1);
		st_chk(8'h2e);
		wr(rcs_pkg::ADDR_STATUS, 1, 40'h20);
		auto_ack <= 1'b1;
		pulse(1, 1);
		st_chk(8'h0e);
		pulse(2, 1);
		st_chk(8'h2e);
		pipe_no <= 3'h3;
		tx_full <= 1'b1;
		pwr_in <= 1'b1;
		wr(rcs_pkg::ADDR_STATUS, 1, 40'hff);
		wr(rcs_pkg::ADDR_OBSERVE, 1, 40'hff);
		wr(rcs_pkg::ADDR_POWER, 1, 40'hff);
		st_chk(8'h07);
		rd("power", rcs_pkg::ADDR_POWER, 1, 40'h01);
		rd("observe", rcs_pkg::ADDR_OBSERVE, 1, 40'h00);
		rd("unmapped", 5'h1f, 1, 40'h00);
		ign(8'he5, 8'h07);
		chk("channel", 7'h10, radio_channel);
		wr(rcs_pkg::ADDR_AW_SETUP, 1, 40'h01);
		wr(rcs_pkg::ADDR_PIPE0, 3, 40'h12_3456);
		chk("pipe0", 40'he7e7_12_3456, pipe0_receive_address);
		rd("pipe0", rcs_pkg::ADDR_PIPE0, 3, 40'h12_3456);
		wr(rcs_pkg::ADDR_AW_SETUP, 1, 40'h00);
		chk("width", 2'h1, address_width);
		wr(rcs_pkg::ADDR_AW_SETUP, 1, 40'h03);
		wr(rcs_pkg::ADDR_PIPE0, 5, 40'ha1_b2c3_d4e5);
		rd("pipe0", rcs_pkg::ADDR_PIPE0, 5, 40'ha1_b2c3_d4e5);
		@(posedge clk) arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd("channel", rcs_pkg::ADDR_CHANNEL, 1, 40'h02);
		rd("pipe0", rcs_pkg::ADDR_PIPE0, 5, 40'he7_e7e7_e7e7);
		chk("width", 2'h3, address_width);
		results();
	end
endmodule

bind rcs_radio_regs rcs_radio_regs_monitor i_rcs_radio_regs_monitor (.clk, .arst_n, .csn_n, .ack_missed,
	.new_packet_start, .miso_oe, .retransmit_request, .comm_blocked, .radio_channel, .pipe0_receive_address,
	.address_width, .data_rate);
